// >>> rtl/prs_params.svh
// Offsets, field positions, reset values and timing figures of the ramp register group.
// Included by the ramp register files; holds definitions only.
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

// Register offsets on the control port
`define PRS_OFS_OPER_COND 8'h68
`define PRS_OFS_SILENCE 8'h69
`define PRS_OFS_PHASE 8'h6A
`define PRS_OFS_SPREAD_EN 8'h6B
`define PRS_OFS_SPREAD_RANGE 8'h6C
`define PRS_OFS_DIVISOR 8'h6D
`define PRS_OFS_TRI_STEP 8'h6E
`define PRS_OFS_TRI_BOUND 8'h6F

// Reset values
`define PRS_RST_ZERO 8'h00
`define PRS_RST_DIVISOR 8'h50
`define PRS_RST_TRI_STEP 8'h11
`define PRS_RST_TRI_BOUND 8'h24

// Silence report bits
`define PRS_BIT_LEFT_SIL 0
`define PRS_BIT_RIGHT_SIL 1

// Ramp phase setup fields
`define PRS_BIT_PHASE_SYNC 0
`define PRS_BIT_FRAME_SYNC 1
`define PRS_PHASE_LO 2
`define PRS_PHASE_HI 3

// Spread enable setup fields
`define PRS_BIT_TRI_EN 0
`define PRS_BIT_RND_EN 1
`define PRS_BIT_MANUAL 4
`define PRS_BIT_PREDIV 5

// Spread range setup fields
`define PRS_TRI_CTRL_LO 0
`define PRS_TRI_CTRL_HI 3
`define PRS_RND_RANGE_LO 4
`define PRS_RND_RANGE_HI 6

// Triangle step setup fields
`define PRS_RISE_LO 0
`define PRS_RISE_HI 3
`define PRS_FALL_LO 4
`define PRS_FALL_HI 7

// Address pin mode that reports both channels silent
`define PRS_ADR_BOTH_MUTED 5'h03

// Ramp reference: 61.44 MHz over N in manual mode
`define PRS_RAMP_REF_HZ 61440000
`define PRS_AUTO_DIVISOR 8'h50

`endif

// >>> rtl/prs_pkg.sv
// Types shared by the ramp register group.
// Assumes prs_params.svh is available for constants.
package prs_pkg;

    typedef enum logic [1:0] {
        PRS_DEEP_SLEEP = 2'h0,
        PRS_SLEEP = 2'h1,
        PRS_OUTPUTS_FLOATING_STATE = 2'h2,
        PRS_PLAY = 2'h3
    } prs_oper_t;

    // Gray along rise -> fall -> rise
    typedef enum logic {
        PRS_RISE = 1'b0,
        PRS_FALL = 1'b1
    } prs_slope_t;

endpackage

// >>> rtl/prs_sync3.sv
// Three-stage synchroniser with agreement filter for inputs from pins.
// Assumes i_async may change at any time relative to i_clk.
`timescale 1ns/100ps
module prs_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,               // System clock
    input wire logic i_reset_n,           // Async reset, active low
    input wire logic [WIDTH-1:0] i_async, // Raw pin level
    output logic [WIDTH-1:0] o_level      // Filtered level
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    integer k;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level_reg <= '0;
        end else begin
            for (k = 0; k < WIDTH; k = k + 1) begin
                if (s2_reg[k] == s3_reg[k]) begin
                    level_reg[k] <= s3_reg[k];
                end
            end
        end
    end

    assign o_level = level_reg;
endmodule

// >>> rtl/prs_spread_mod.sv
// Spread-spectrum offset generator for the ramp period: triangle sweep or random.
// Assumes i_step pulses once per ramp period; offset is added to the base divisor.
`timescale 1ns/100ps
module prs_spread_mod
    import prs_pkg::*;
#(
    parameter int OFS_W = 8
) (
    input wire logic i_clk,                // System clock
    input wire logic i_reset_n,            // Async reset, active low
    input wire logic i_step,               // Advance once per period
    input wire logic i_tri_en,             // Triangle sweep on
    input wire logic i_rnd_en,             // Random spread on
    input wire logic i_manual,             // Manual step sizes in force
    input wire logic [3:0] i_tri_ctrl,     // Triangle range in automatic and manual mode
    input wire logic [2:0] i_rnd_range,    // Random range
    input wire logic [3:0] i_rise_step,    // Manual rise step
    input wire logic [3:0] i_fall_step,    // Manual fall step
    output logic [OFS_W-1:0] o_offset      // Period offset in ramp ticks
);
    prs_slope_t slope_reg;
    logic [OFS_W-1:0] tri_reg;
    logic [15:0] lfsr_reg;
    logic [OFS_W-1:0] offset_reg;
    logic [OFS_W-1:0] tri_limit;
    logic [OFS_W-1:0] up_step;
    logic [OFS_W-1:0] dn_step;
    logic [OFS_W-1:0] rnd_mask;

    always_comb begin
        tri_limit = {{(OFS_W-4){1'b0}}, i_tri_ctrl} << 2;
        up_step = i_manual ? {{(OFS_W-4){1'b0}}, i_rise_step} : {{(OFS_W-1){1'b0}}, 1'b1};
        dn_step = i_manual ? {{(OFS_W-4){1'b0}}, i_fall_step} : {{(OFS_W-1){1'b0}}, 1'b1};
        // Shift amount is widened first so the top range does not wrap to zero
        rnd_mask = (OFS_W)'(({{(OFS_W-1){1'b0}}, 1'b1} << ({1'b0, i_rnd_range} + 4'h1)) - 1);
    end

    // Triangle sweep; the turn points clip so a large step never overshoots
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            slope_reg <= PRS_RISE;
            tri_reg <= '0;
        end else if (!i_tri_en) begin
            slope_reg <= PRS_RISE;
            tri_reg <= '0;
        end else if (i_step) begin
            case (slope_reg)
                PRS_RISE: begin
                    if (tri_reg + up_step >= tri_limit) begin
                        tri_reg <= tri_limit;
                        slope_reg <= PRS_FALL;
                    end else begin
                        tri_reg <= tri_reg + up_step;
                    end
                end
                PRS_FALL: begin
                    if (tri_reg <= dn_step) begin
                        tri_reg <= '0;
                        slope_reg <= PRS_RISE;
                    end else begin
                        tri_reg <= tri_reg - dn_step;
                    end
                end
                default: begin
                    slope_reg <= PRS_RISE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lfsr_reg <= 16'hACE1;
        end else if (i_step) begin
            lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        end
    end

    // Triangle wins when both modes are on
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            offset_reg <= '0;
        end else if (i_tri_en) begin
            offset_reg <= tri_reg;
        end else if (i_rnd_en) begin
            offset_reg <= lfsr_reg[OFS_W-1:0] & rnd_mask;
        end else begin
            offset_reg <= '0;
        end
    end

    assign o_offset = offset_reg;
endmodule

// >>> rtl/prs_ramp_regs.sv
// Ramp phase and spread-spectrum register group with power and silence reports.
// Assumes a control-port byte access already decoded from the serial control bus,
// status inputs from same-clock logic, and the audio frame clock straight from its pin.
// Functional notes
// (RULE_01) The byte at 0x68 reads the operating state: 0 deep sleep, 1 sleep, 2 floating, 3 play.
// (RULE_02) Bit 1 of the silence report reads 1 exactly while the right channel is auto muted.
// (RULE_03) Bit 0 of the silence report reads 1 exactly while the left channel is auto muted.
// (RULE_04) Bits 3-2 of the phase setup pick ramp phase 0 to 3 and reset to 00.
// (RULE_05) Software writes the phase choice before it puts the device into play.
// (RULE_06) Staggered devices are all given the same ramp frequency and spread settings.
// (RULE_07) Bit 1 of the phase setup aligns the output PWM phase to the audio framing.
// (RULE_08) Bit 0 of the phase setup enables ramp phase sync and resets to 0.
// (RULE_09) In manual mode bit 5 of the first spread byte runs the ramp from the clock halved.
// (RULE_10) Bit 4 of the first spread byte puts the spread controller in manual mode, reset 0.
// (RULE_11) Bit 1 of the first spread byte enables random spread, its range in bits 6-4 of the second.
// (RULE_12) Bit 0 of the first spread byte enables triangle spread, set by bits 3-0 of the second.
// (RULE_13) In manual mode the divisor N in the third spread byte sets the ramp to 61.44 MHz over N.
// (RULE_14) In manual mode bits 7-4 of the fourth spread byte set the triangle fall step, reset 0001.
// (RULE_15) In manual mode bits 3-0 of the fourth spread byte set the triangle rise step, reset 0001.
// (RULE_16) With address pin mode 00011 the pin flag is high only while both channels are muted.
// (RULE_17) Reserved status bits read zero and writes to the status bytes change nothing.
`timescale 1ns/100ps
`include "prs_params.svh"
module prs_ramp_regs
    import prs_pkg::*;
#(
    parameter int PER_W = 10
) (
    input wire logic I_CLK,               // System clock, 50 MHz
    input wire logic I_RESET_N,           // Async reset, active low
    input wire logic [7:0] I_REG_ADDR,    // Control port byte address
    input wire logic I_REG_WR,            // Write strobe, one cycle
    input wire logic [7:0] I_REG_WDATA,   // Write data
    input wire logic I_REG_RD,            // Read strobe, one cycle
    output logic [7:0] O_REG_RDATA,       // Read data, valid cycle after I_REG_RD
    input wire logic [1:0] I_OPER_CODE,   // Operating state from the power sequencer
    input wire logic I_LEFT_SILENCE,      // Left channel auto muted
    input wire logic I_RIGHT_SILENCE,     // Right channel auto muted
    input wire logic [4:0] I_ADR_MODE,    // Address pin function select
    output logic O_ADR_FLAG,              // Address pin function output
    input wire logic I_FRAME_CLK,         // Audio frame clock pin, asynchronous
    input wire logic I_PHASE_SYNC,        // Ramp phase sync from peer logic, pulse
    output logic O_RAMP_START,            // Ramp period start, one-cycle pulse
    output logic [1:0] O_RAMP_PHASE,      // Selected ramp phase
    output logic [PER_W-1:0] O_RAMP_PERIOD, // Current period in ramp ticks
    output logic [7:0] O_TRI_BOUND        // Stored triangle bound setup byte
);
    // Ramp source reference; the system clock stands in for the PLL here
    localparam longint RAMP_REF_HZ = `PRS_RAMP_REF_HZ;

    logic [7:0] phase_reg;
    logic [7:0] spread_en_reg;
    logic [7:0] spread_range_reg;
    logic [7:0] divisor_reg;
    logic [7:0] tri_step_reg;
    logic [7:0] tri_bound_reg;
    logic [7:0] rdata_reg;
    logic [7:0] oper_reg;
    logic [7:0] silence_reg;
    logic adr_flag_reg;
    logic frame_level;
    logic frame_prev_reg;
    logic frame_edge;
    logic prediv_reg;
    logic ramp_tick;
    logic [PER_W-1:0] count_reg;
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] period_reg;
    logic start_reg;
    logic restart;
    logic [7:0] spread_offset;
    logic manual;
    prs_oper_t oper_code;

    // One place decides whether an address is a writable setup byte
    function automatic logic is_setup(input logic [7:0] addr);
        is_setup = (addr >= `PRS_OFS_PHASE) && (addr <= `PRS_OFS_TRI_BOUND);
    endfunction

    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs, input logic wr);
        wr_hit = wr && is_setup(addr) && (addr == ofs);
    endfunction

    assign manual = spread_en_reg[`PRS_BIT_MANUAL];
    assign oper_code = prs_oper_t'(I_OPER_CODE);

    // Status bytes only follow the device state; writes never reach them
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            oper_reg <= `PRS_RST_ZERO;
        end else begin
            oper_reg <= {6'h00, oper_code}; // [RULE_01] [RULE_17]
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            silence_reg <= `PRS_RST_ZERO;
        end else begin
            silence_reg <= `PRS_RST_ZERO; // [RULE_17]
            silence_reg[`PRS_BIT_RIGHT_SIL] <= I_RIGHT_SILENCE; // [RULE_02]
            silence_reg[`PRS_BIT_LEFT_SIL] <= I_LEFT_SILENCE; // [RULE_03]
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            adr_flag_reg <= 1'b0;
        end else begin
            adr_flag_reg <= (I_ADR_MODE == `PRS_ADR_BOTH_MUTED)
                && I_LEFT_SILENCE && I_RIGHT_SILENCE; // [RULE_16]
        end
    end

    // Phase choice is taken at any time; software sets it before play
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            phase_reg <= `PRS_RST_ZERO; // [RULE_04] [RULE_08]
        end else if (wr_hit(I_REG_ADDR, `PRS_OFS_PHASE, I_REG_WR)) begin
            phase_reg <= I_REG_WDATA; // [RULE_05]
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            spread_en_reg <= `PRS_RST_ZERO; // [RULE_10]
        end else if (wr_hit(I_REG_ADDR, `PRS_OFS_SPREAD_EN, I_REG_WR)) begin
            spread_en_reg <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            spread_range_reg <= `PRS_RST_ZERO;
        end else if (wr_hit(I_REG_ADDR, `PRS_OFS_SPREAD_RANGE, I_REG_WR)) begin
            spread_range_reg <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            divisor_reg <= `PRS_RST_DIVISOR; // [RULE_13]
        end else if (wr_hit(I_REG_ADDR, `PRS_OFS_DIVISOR, I_REG_WR)) begin
            divisor_reg <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            tri_step_reg <= `PRS_RST_TRI_STEP; // [RULE_14] [RULE_15]
        end else if (wr_hit(I_REG_ADDR, `PRS_OFS_TRI_STEP, I_REG_WR)) begin
            tri_step_reg <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            tri_bound_reg <= `PRS_RST_TRI_BOUND;
        end else if (wr_hit(I_REG_ADDR, `PRS_OFS_TRI_BOUND, I_REG_WR)) begin
            tri_bound_reg <= I_REG_WDATA;
        end
    end

    // Read mux; unmapped addresses answer zero
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata_reg <= `PRS_RST_ZERO;
        end else if (I_REG_RD) begin
            if (I_REG_ADDR == `PRS_OFS_OPER_COND) begin
                rdata_reg <= oper_reg; // [RULE_01]
            end else if (I_REG_ADDR == `PRS_OFS_SILENCE) begin
                rdata_reg <= silence_reg; // [RULE_02] [RULE_03]
            end else if (I_REG_ADDR == `PRS_OFS_PHASE) begin
                rdata_reg <= phase_reg;
            end else if (I_REG_ADDR == `PRS_OFS_SPREAD_EN) begin
                rdata_reg <= spread_en_reg;
            end else if (I_REG_ADDR == `PRS_OFS_SPREAD_RANGE) begin
                rdata_reg <= spread_range_reg;
            end else if (I_REG_ADDR == `PRS_OFS_DIVISOR) begin
                rdata_reg <= divisor_reg;
            end else if (I_REG_ADDR == `PRS_OFS_TRI_STEP) begin
                rdata_reg <= tri_step_reg;
            end else if (I_REG_ADDR == `PRS_OFS_TRI_BOUND) begin
                rdata_reg <= tri_bound_reg;
            end else begin
                rdata_reg <= `PRS_RST_ZERO;
            end
        end
    end

    // Frame clock arrives from a pin, so it is filtered before edge detection
    prs_sync3 #(
        .WIDTH(1)
    ) u_frame_sync (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_async(I_FRAME_CLK),
        .o_level(frame_level)
    );

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            frame_prev_reg <= 1'b0;
        end else begin
            frame_prev_reg <= frame_level;
        end
    end

    assign frame_edge = frame_level && !frame_prev_reg;

    // Halved source clock only counts in manual mode
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            prediv_reg <= 1'b0;
        end else begin
            prediv_reg <= !prediv_reg;
        end
    end

    assign ramp_tick = !(manual && spread_en_reg[`PRS_BIT_PREDIV]) || prediv_reg; // [RULE_09]

    prs_spread_mod #(
        .OFS_W(8)
    ) u_spread (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_step(start_reg),
        .i_tri_en(spread_en_reg[`PRS_BIT_TRI_EN]), // [RULE_12]
        .i_rnd_en(spread_en_reg[`PRS_BIT_RND_EN]), // [RULE_11]
        .i_manual(manual),
        .i_tri_ctrl(spread_range_reg[`PRS_TRI_CTRL_HI:`PRS_TRI_CTRL_LO]), // [RULE_12]
        .i_rnd_range(spread_range_reg[`PRS_RND_RANGE_HI:`PRS_RND_RANGE_LO]), // [RULE_11]
        .i_rise_step(tri_step_reg[`PRS_RISE_HI:`PRS_RISE_LO]), // [RULE_15]
        .i_fall_step(tri_step_reg[`PRS_FALL_HI:`PRS_FALL_LO]), // [RULE_14]
        .o_offset(spread_offset)
    );

    // Period is N ticks of the reference in manual mode, else 0x50 ticks, plus the spread offset; a zero sum is held at one tick
    always_comb begin
        period = PER_W'(manual ? divisor_reg : `PRS_AUTO_DIVISOR) + PER_W'(spread_offset); // [RULE_13]
        if (period == '0) begin
            period = PER_W'(1);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            period_reg <= PER_W'(`PRS_RST_DIVISOR);
        end else if (start_reg) begin
            period_reg <= period;
        end
    end

    assign restart = (phase_reg[`PRS_BIT_PHASE_SYNC] && I_PHASE_SYNC) // [RULE_08]
        || (phase_reg[`PRS_BIT_FRAME_SYNC] && frame_edge); // [RULE_07]

    // Restart loads a quarter-period offset per phase step to stagger devices
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            count_reg <= '0;
            start_reg <= 1'b0;
        end else if (restart) begin
            count_reg <= PER_W'((period_reg >> 2) * phase_reg[`PRS_PHASE_HI:`PRS_PHASE_LO]); // [RULE_04]
            start_reg <= 1'b0;
        end else if (ramp_tick) begin
            if (count_reg >= period_reg - PER_W'(1)) begin
                count_reg <= '0;
                start_reg <= 1'b1;
            end else begin
                count_reg <= count_reg + PER_W'(1);
                start_reg <= 1'b0;
            end
        end else begin
            start_reg <= 1'b0;
        end
    end

    assign O_REG_RDATA = rdata_reg;
    assign O_ADR_FLAG = adr_flag_reg;
    assign O_RAMP_START = start_reg;
    assign O_RAMP_PHASE = phase_reg[`PRS_PHASE_HI:`PRS_PHASE_LO]; // [RULE_04]
    assign O_RAMP_PERIOD = period_reg;
    assign O_TRI_BOUND = tri_bound_reg;
endmodule

// >>> testbench/prs_ramp_regs_sva.sv
// Port-level checker for the ramp register group.
// Assumes status inputs reach readout two cycles later and reads answer one cycle on.
`timescale 1ns/100ps
module prs_ramp_regs_sva #(
    parameter int PER_W = 10
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_RD,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic [1:0] I_OPER_CODE,
    input wire logic I_LEFT_SILENCE,
    input wire logic I_RIGHT_SILENCE,
    input wire logic [4:0] I_ADR_MODE,
    input wire logic O_ADR_FLAG,
    input wire logic O_RAMP_START,
    input wire logic [1:0] O_RAMP_PHASE,
    input wire logic [PER_W-1:0] O_RAMP_PERIOD
);
    logic [1:0] up_reg;
    logic [7:0] wd_reg;
    // Status history is meaningless until inputs were sampled after release
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            up_reg <= 2'h0;
        end else if (up_reg != 2'h3) begin
            up_reg <= up_reg + 2'h1;
        end
    end
    always_ff @(posedge I_CLK) begin
        wd_reg <= I_REG_WDATA;
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_wr_cfg;
        I_REG_WR && I_REG_ADDR >= 8'h6A && I_REG_ADDR <= 8'h6F;
    endsequence
    sequence s_rd_back;
        I_REG_RD && !I_REG_WR && I_REG_ADDR == $past(I_REG_ADDR);
    endsequence
    oper_read_a: assert property (
        up_reg == 2'h3 && I_REG_RD && I_REG_ADDR == 8'h68 |=>
        O_REG_RDATA == {6'h00, $past(I_OPER_CODE, 2)}) else $error("oper byte wrong");
    silence_read_a: assert property (
        up_reg == 2'h3 && I_REG_RD && I_REG_ADDR == 8'h69 |=> O_REG_RDATA ==
        {6'h00, $past(I_RIGHT_SILENCE, 2), $past(I_LEFT_SILENCE, 2)}) else $error("silence wrong");
    unmapped_zero_a: assert property (
        I_REG_RD && (I_REG_ADDR < 8'h68 || I_REG_ADDR > 8'h6F) |=> O_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    cfg_echo_a: assert property (
        s_wr_cfg ##1 s_rd_back |=> O_REG_RDATA == $past(I_REG_WDATA, 2))
        else $error("config readback wrong");
    adr_flag_a: assert property (
        up_reg != 2'h0 |-> O_ADR_FLAG ==
        $past(I_ADR_MODE == 5'h03 && I_LEFT_SILENCE && I_RIGHT_SILENCE)) else $error("flag wrong");
    phase_out_a: assert property (
        I_REG_WR && I_REG_ADDR == 8'h6A |=> O_RAMP_PHASE == wd_reg[3:2])
        else $error("phase output wrong");
    rdata_hold_a: assert property (
        !I_REG_RD |=> $stable(O_REG_RDATA)) else $error("read data moved");
    period_hold_a: assert property (
        !O_RAMP_START |=> $stable(O_RAMP_PERIOD)) else $error("period moved off wrap");
endmodule
bind prs_ramp_regs prs_ramp_regs_sva #(.PER_W(PER_W)) u_sva (.*);

// >>> testbench/prs_ramp_regs_tb_top.sv
// Self-checking bench for the ramp register group.
// Assumes the byte port contract: strobes one cycle, read data one cycle later.
`timescale 1ns/100ps
module prs_ramp_regs_tb_top;
    logic I_CLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic [7:0] I_REG_ADDR = 8'h00;
    logic I_REG_WR = 1'b0;
    logic [7:0] I_REG_WDATA = 8'h00;
    logic I_REG_RD = 1'b0;
    logic [1:0] I_OPER_CODE = 2'h0;
    logic I_LEFT_SILENCE = 1'b0;
    logic I_RIGHT_SILENCE = 1'b0;
    logic [4:0] I_ADR_MODE = 5'h00;
    logic I_FRAME_CLK = 1'b0;
    logic I_PHASE_SYNC = 1'b0;
    logic [7:0] O_REG_RDATA;
    logic O_ADR_FLAG;
    logic O_RAMP_START;
    logic [1:0] O_RAMP_PHASE;
    logic [9:0] O_RAMP_PERIOD;
    logic [7:0] O_TRI_BOUND;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 43011;
    logic [7:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic [7:0] v;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h11, 8'h24};
    int d0, d2, n, diff;

    prs_ramp_regs u_dut (.*);
    always #10 I_CLK = ~I_CLK;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Strobes are only set here, never cleared at task exit, so calls chain back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        I_REG_ADDR <= a;
        I_REG_WDATA <= d;
        I_REG_WR <= 1'b1;
        I_REG_RD <= 1'b0;
        @(posedge I_CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        I_REG_ADDR <= a;
        I_REG_RD <= 1'b1;
        I_REG_WR <= 1'b0;
        exp_q.push_back(e);
        @(posedge I_CLK);
    endtask
    task automatic idle(input int c);
        I_REG_WR <= 1'b0;
        I_REG_RD <= 1'b0;
        repeat (c) @(posedge I_CLK);
    endtask
    task automatic to_start(output int c);
        c = 0;
        do begin
            @(posedge I_CLK);
            c++;
        end while (O_RAMP_START !== 1'b1 && c < 2000);
        if (c >= 2000) begin
            fail_count++;
            finish_test();
        end
    endtask
    // Restart right after a wrap so no natural wrap falls inside the sync latency
    task automatic sync_gap(input logic fr, input logic [1:0] ph, output int c);
        wr(8'h6A, {4'h0, ph, fr, ~fr});
        idle(1);
        to_start(c);
        if (fr) I_FRAME_CLK <= 1'b1;
        else I_PHASE_SYNC <= 1'b1;
        @(posedge I_CLK);
        I_PHASE_SYNC <= 1'b0;
        to_start(c);
        I_FRAME_CLK <= 1'b0;
    endtask

    always @(posedge I_CLK) begin
        if (rd_pend) check(16'(O_REG_RDATA), 16'(exp_q.pop_front()));
        rd_pend <= I_REG_RD;
    end

    initial begin
        repeat (5) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        idle(3);
        check(16'(O_RAMP_PERIOD), 16'h0050);
        for (int i = 0; i < 8; i++) rd(8'h68 + 8'(i), rst_tab[i]);
        for (int i = 2; i < 8; i++) begin
            v = 8'($random(seed));
            wr(8'h68 + 8'(i), v);
            rd(8'h68 + 8'(i), v);
        end
        idle(1);
        check(16'(O_TRI_BOUND), 16'(v));
        wr(8'h68, 8'hFF);
        wr(8'h69, 8'hFF);
        wr(8'h70, 8'h55);
        idle(3);
        rd(8'h68, 8'h00);
        rd(8'h69, 8'h00);
        rd(8'h70, 8'h00);
        rd(8'h00, 8'h00);
        for (int k = 0; k < 8; k++) begin
            I_OPER_CODE <= 2'(k);
            I_LEFT_SILENCE <= k[0];
            I_RIGHT_SILENCE <= k[1];
            I_ADR_MODE <= k[2] ? 5'h04 : 5'h03;
            idle(3);
            rd(8'h68, 8'(k % 4));
            rd(8'h69, 8'(k % 4));
            check(16'(O_ADR_FLAG), 16'(k == 3));
        end
        wr(8'h6C, 8'h71);
        wr(8'h6D, 8'h04);
        wr(8'h6B, 8'h10);
        idle(1);
        to_start(n);
        to_start(n);
        check(16'(n), 16'd4);
        check(16'(O_RAMP_PERIOD), 16'h0004);
        wr(8'h6B, 8'h30);
        idle(1);
        to_start(n);
        to_start(n);
        check(16'(n), 16'd8);
        wr(8'h6B, 8'h00);
        idle(1);
        to_start(n);
        to_start(n);
        check(16'(n), 16'd80);
        wr(8'h6E, 8'h11);
        wr(8'h6D, 8'd64);
        for (int j = 0; j < 2; j++) begin
            wr(8'h6B, j ? 8'h12 : 8'h11);
            idle(1);
            diff = 0;
            for (int g = 0; g < 6; g++) begin
                to_start(n);
                if (n != 64) diff++;
            end
            check(16'(diff > 0), 16'h0001);
        end
        wr(8'h6B, 8'h10);
        for (int f = 0; f < 2; f++) begin
            sync_gap(f[0], 2'h0, d0);
            sync_gap(f[0], 2'h2, d2);
            check(16'(O_RAMP_PHASE), 16'h0002);
            check(16'(d0 - d2), 16'd32);
        end
        idle(2);
        finish_test();
    end
endmodule
